// ---- src/cpu_oag_pkg.sv ----
package cpu_oag_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] IDX_RESET = 8'h00;
	localparam logic [7:0] PAGE_ZERO = 8'h00;

	typedef enum logic [1:0] {
		cls_reg_mem,
		cls_rmw,
		cls_branch
	} iclass_t;

	typedef enum logic [2:0] {
		mode_inh_a,
		mode_inh_x,
		mode_dir,
		mode_ext,
		mode_ix,
		mode_ix1,
		mode_ix2,
		mode_rel
	} amode_t;

	typedef enum logic [4:0] {
		add_op,
		add_carry_op,
		and_acc_op,
		bit_test_op,
		compare_acc_op,
		compare_index_op,
		xor_acc_op,
		load_acc_op,
		load_index_op,
		product_op,
		or_acc_op,
		subtract_op,
		subtract_borrow_op,
		store_acc_op,
		store_index_op,
		shift_left_arith_op,
		shift_right_arith_op,
		shift_left_logic_op,
		shift_right_logic_op,
		rotate_left_carry_op,
		rotate_right_carry_op,
		bit_reset_op,
		bit_raise_op,
		zero_fill_op,
		bitwise_invert_op,
		arithmetic_invert_op,
		plus_one_op,
		minus_one_op,
		test_flags_only_op,
		branch_op
	} op_t;

	typedef struct packed {
		iclass_t iclass;
		amode_t mode;
		op_t op;
		logic [2:0] bit_sel;
		logic [7:0] byte1;
		logic [7:0] byte2;
		logic [15:0] pc;
		logic cond;
	} instr_t;

	typedef struct packed {
		logic h;
		logic n;
		logic z;
		logic c;
	} flags_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mem_req_t;

	localparam flags_t FLAGS_RESET = '{h: 1'b0, n: 1'b0, z: 1'b0, c: 1'b0};

endpackage : cpu_oag_pkg

// ---- src/cpu_operand_address_generator.sv ----
// Notes on behaviour
// - Direct mode: address is zero high byte, first operand byte low.
// - Extended mode: first operand byte high, second byte low address half.
// - Indexed no offset: index register low byte, zero high byte.
// - Indexed byte offset: unsigned index plus unsigned byte, full nine-bit sum.
// - Indexed word offset: index plus word, high byte first after opcode.
// - Taken branch adds signed offset to next-instruction counter; else fall through.
// - Relative mode is accepted only for branches.
// - Register/memory ops pair accumulator or index with a memory byte; product pairs accumulator with index.
// - Register/memory set: add, adc, and, bit, compares, xor, loads, stores, product, or, subtracts.
// - Read-modify-write reads, alters, writes back to the same place.
// - Read-modify-write set: shifts, rotates, clear, invert, negate, inc, dec, bits, test.
// - Bit set and bit clear accept direct mode only.
// - Test reads and updates flags but writes nothing back.
// - Product of accumulator and index: high byte to index, low to accumulator.
`timescale 1ns/1ps
`default_nettype none

module cpu_operand_address_generator
	import cpu_oag_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire instr_t instr,
	input wire logic instr_valid,
	output logic instr_ready,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	output mem_req_t mem,
	output logic done,
	output logic illegal,
	output logic [15:0] pc_out,
	output logic [7:0] acc,
	output logic [7:0] idx,
	output flags_t flags
);

	typedef enum {st_idle, st_read, st_write} state_t;

	state_t state_reg;
	mem_req_t mem_reg;
	op_t op_reg;
	logic [2:0] bit_reg;
	logic done_reg, illegal_reg;
	logic [15:0] pc_reg;
	logic [7:0] acc_reg, idx_reg;
	flags_t flags_reg;

	logic take, bad, is_rmw_reg, from_mem;
	logic [15:0] ea_next;
	op_t alu_op;
	logic [2:0] alu_bit;
	logic [7:0] alu_in, res, mask;
	logic [8:0] wide;
	logic [15:0] prod;
	logic upd_nz, upd_c, upd_h, wr_acc, wr_idx, wr_back, new_c, new_h;

	assign instr_ready = (state_reg == st_idle);
	assign take = instr_valid && instr_ready;
	assign is_rmw_reg = (instr.mode == mode_inh_a) || (instr.mode == mode_inh_x);

	always_comb begin
		bad = 1'b0;
		if ((instr.mode == mode_rel) != (instr.iclass == cls_branch)) begin
			bad = 1'b1;
		end
		if ((instr.op == bit_raise_op || instr.op == bit_reset_op) && instr.mode != mode_dir) begin
			bad = 1'b1;
		end
		if (instr.iclass == cls_reg_mem && is_rmw_reg && instr.op != product_op) begin
			bad = 1'b1;
		end
		if (instr.op == product_op && instr.mode != mode_inh_a) begin
			bad = 1'b1;
		end
	end

	always_comb begin
		case (instr.mode)
			mode_dir: ea_next = {PAGE_ZERO, instr.byte1};
			mode_ext: ea_next = {instr.byte1, instr.byte2};
			mode_ix: ea_next = {PAGE_ZERO, idx_reg};
			mode_ix1: ea_next = {PAGE_ZERO, instr.byte1} + {PAGE_ZERO, idx_reg};
			mode_ix2: ea_next = {instr.byte1, instr.byte2} + {PAGE_ZERO, idx_reg};
			default: ea_next = ADDR_RESET;
		endcase
	end

	// The arithmetic unit sees the register operand in the accept cycle and the memory byte later.
	assign from_mem = (state_reg == st_read);
	assign alu_op = from_mem ? op_reg : instr.op;
	assign alu_bit = from_mem ? bit_reg : instr.bit_sel;
	assign mask = 8'h01 << alu_bit;

	always_comb begin
		if (from_mem) begin
			alu_in = mem_rdata;
		end else if (instr.mode == mode_inh_x) begin
			alu_in = idx_reg;
		end else begin
			alu_in = acc_reg;
		end
	end

	always_comb begin
		wide = 9'h000;
		prod = {8'h00, acc_reg} * {8'h00, idx_reg};
		res = alu_in;
		upd_nz = 1'b1;
		upd_c = 1'b0;
		upd_h = 1'b0;
		new_c = flags_reg.c;
		new_h = flags_reg.h;
		wr_acc = 1'b0;
		wr_idx = 1'b0;
		wr_back = 1'b0;
		case (alu_op)
			add_op, add_carry_op: begin
				wide = {1'b0, acc_reg} + {1'b0, alu_in} + {8'h00, alu_op == add_carry_op && flags_reg.c};
				res = wide[7:0];
				new_c = wide[8];
				new_h = (acc_reg[4] ^ alu_in[4] ^ res[4]);
				upd_c = 1'b1;
				upd_h = 1'b1;
				wr_acc = 1'b1;
			end
			subtract_op, subtract_borrow_op, compare_acc_op, compare_index_op: begin
				wide = {1'b0, (alu_op == compare_index_op) ? idx_reg : acc_reg} - {1'b0, alu_in}
					- {8'h00, alu_op == subtract_borrow_op && flags_reg.c};
				res = wide[7:0];
				new_c = wide[8];
				upd_c = 1'b1;
				wr_acc = (alu_op == subtract_op) || (alu_op == subtract_borrow_op);
			end
			and_acc_op, bit_test_op: begin
				res = acc_reg & alu_in;
				wr_acc = (alu_op == and_acc_op);
			end
			xor_acc_op: begin
				res = acc_reg ^ alu_in;
				wr_acc = 1'b1;
			end
			or_acc_op: begin
				res = acc_reg | alu_in;
				wr_acc = 1'b1;
			end
			load_acc_op: wr_acc = 1'b1;
			load_index_op: wr_idx = 1'b1;
			store_acc_op: res = acc_reg;
			store_index_op: res = idx_reg;
			product_op: begin
				upd_nz = 1'b0;
				upd_c = 1'b1;
				upd_h = 1'b1;
				new_c = 1'b0;
				new_h = 1'b0;
			end
			shift_left_arith_op, shift_left_logic_op: begin
				res = {alu_in[6:0], 1'b0};
				new_c = alu_in[7];
				upd_c = 1'b1;
				wr_back = 1'b1;
			end
			shift_right_arith_op: begin
				res = {alu_in[7], alu_in[7:1]};
				new_c = alu_in[0];
				upd_c = 1'b1;
				wr_back = 1'b1;
			end
			shift_right_logic_op: begin
				res = {1'b0, alu_in[7:1]};
				new_c = alu_in[0];
				upd_c = 1'b1;
				wr_back = 1'b1;
			end
			rotate_left_carry_op: begin
				res = {alu_in[6:0], flags_reg.c};
				new_c = alu_in[7];
				upd_c = 1'b1;
				wr_back = 1'b1;
			end
			rotate_right_carry_op: begin
				res = {flags_reg.c, alu_in[7:1]};
				new_c = alu_in[0];
				upd_c = 1'b1;
				wr_back = 1'b1;
			end
			zero_fill_op: begin
				res = 8'h00;
				new_c = 1'b0;
				upd_c = 1'b1;
				wr_back = 1'b1;
			end
			bitwise_invert_op: begin
				res = ~alu_in;
				new_c = 1'b1;
				upd_c = 1'b1;
				wr_back = 1'b1;
			end
			arithmetic_invert_op: begin
				res = 8'h00 - alu_in;
				new_c = (res != 8'h00);
				upd_c = 1'b1;
				wr_back = 1'b1;
			end
			plus_one_op: begin
				res = alu_in + 8'h01;
				wr_back = 1'b1;
			end
			minus_one_op: begin
				res = alu_in - 8'h01;
				wr_back = 1'b1;
			end
			bit_raise_op: begin
				res = alu_in | mask;
				upd_nz = 1'b0;
				wr_back = 1'b1;
			end
			bit_reset_op: begin
				res = alu_in & ~mask;
				upd_nz = 1'b0;
				wr_back = 1'b1;
			end
			test_flags_only_op: wr_back = 1'b0;
			default: upd_nz = 1'b0;
		endcase
	end

	logic finish_now;
	assign finish_now = (take && (bad || instr.iclass == cls_branch || is_rmw_reg))
		|| (state_reg == st_read && mem_ack && !wr_back)
		|| (state_reg == st_write && mem_ack);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= st_idle;
			mem_reg <= '{req: 1'b0, we: 1'b0, addr: ADDR_RESET, wdata: ACC_RESET};
			op_reg <= test_flags_only_op;
			bit_reg <= 3'h0;
		end else begin
			case (state_reg)
				st_idle: begin
					if (take && !bad && instr.iclass != cls_branch && !is_rmw_reg) begin
						op_reg <= instr.op;
						bit_reg <= instr.bit_sel;
						mem_reg.req <= 1'b1;
						mem_reg.addr <= ea_next;
						if (instr.op == store_acc_op || instr.op == store_index_op) begin
							mem_reg.we <= 1'b1;
							mem_reg.wdata <= (instr.op == store_acc_op) ? acc_reg : idx_reg;
							state_reg <= st_write;
						end else begin
							mem_reg.we <= 1'b0;
							state_reg <= st_read;
						end
					end
				end
				st_read: begin
					if (mem_ack) begin
						if (wr_back) begin
							mem_reg.we <= 1'b1;
							mem_reg.wdata <= res;
							state_reg <= st_write;
						end else begin
							mem_reg.req <= 1'b0;
							state_reg <= st_idle;
						end
					end
				end
				st_write: begin
					if (mem_ack) begin
						mem_reg.req <= 1'b0;
						mem_reg.we <= 1'b0;
						state_reg <= st_idle;
					end
				end
				default: state_reg <= st_idle;
			endcase
		end
	end

	// Registers and flags are only touched once the operand is known, never on a refused request.
	logic alu_fire;
	assign alu_fire = (take && !bad && is_rmw_reg) || (state_reg == st_read && mem_ack)
		|| (take && !bad && (instr.op == store_acc_op || instr.op == store_index_op));

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			acc_reg <= ACC_RESET;
			idx_reg <= IDX_RESET;
			flags_reg <= FLAGS_RESET;
		end else if (alu_fire) begin
			if (alu_op == product_op) begin
				idx_reg <= prod[15:8];
				acc_reg <= prod[7:0];
			end else if (wr_acc || (wr_back && !from_mem && instr.mode == mode_inh_a)) begin
				acc_reg <= res;
			end else if (wr_idx || (wr_back && !from_mem && instr.mode == mode_inh_x)) begin
				idx_reg <= res;
			end
			if (upd_nz) begin
				flags_reg.n <= res[7];
				flags_reg.z <= (res == 8'h00);
			end
			if (upd_c) begin
				flags_reg.c <= new_c;
			end
			if (upd_h) begin
				flags_reg.h <= new_h;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pc_reg <= PC_RESET;
			done_reg <= 1'b0;
			illegal_reg <= 1'b0;
		end else begin
			done_reg <= finish_now;
			if (take) begin
				illegal_reg <= bad;
			end
			if (take && !bad && instr.iclass == cls_branch) begin
				pc_reg <= instr.cond ? instr.pc + {{8{instr.byte1[7]}}, instr.byte1} : instr.pc;
			end
		end
	end

	assign mem = mem_reg;
	assign done = done_reg;
	assign illegal = illegal_reg;
	assign pc_out = pc_reg;
	assign acc = acc_reg;
	assign idx = idx_reg;
	assign flags = flags_reg;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	logic take_mem;
	assign take_mem = take && !bad && instr.iclass != cls_branch && !is_rmw_reg;

	a_direct_page_zero: assert property (take_mem && instr.mode == mode_dir |=>
		mem.req && mem.addr == {8'h00, $past(instr.byte1)})
		else $error("direct address not in page zero");
	a_extended_order: assert property (take_mem && instr.mode == mode_ext |=>
		mem.addr == {$past(instr.byte1), $past(instr.byte2)})
		else $error("extended address bytes misordered");
	a_index_plain: assert property (take_mem && instr.mode == mode_ix |=>
		mem.addr == {8'h00, $past(idx_reg)})
		else $error("indexed address wrong");
	a_index_byte_sum: assert property (take_mem && instr.mode == mode_ix1 |=>
		mem.addr == 16'({8'h00, $past(instr.byte1)} + {8'h00, $past(idx_reg)}) && mem.addr <= 16'h01FE)
		else $error("byte offset sum wrong");
	a_index_word_sum: assert property (take_mem && instr.mode == mode_ix2 |=>
		mem.addr == 16'({$past(instr.byte1), $past(instr.byte2)} + {8'h00, $past(idx_reg)}))
		else $error("word offset sum wrong");
	a_branch_target: assert property (take && !bad && instr.iclass == cls_branch |=>
		done && pc_out == ($past(instr.cond) ? 16'($past(instr.pc) + {{8{$past(instr.byte1[7])}},
		$past(instr.byte1)}) : $past(instr.pc)))
		else $error("branch target wrong");
	a_rel_branch_only: assert property (take && instr.mode == mode_rel && instr.iclass != cls_branch
		|=> illegal && !mem.req)
		else $error("relative mode accepted outside branch");
	a_bitop_direct: assert property (take && (instr.op == bit_raise_op || instr.op == bit_reset_op)
		&& instr.mode != mode_dir |=> illegal && !mem.req)
		else $error("bit op accepted outside direct mode");
	a_test_no_write: assert property (state_reg == st_read && op_reg == test_flags_only_op && mem_ack
		|=> !mem.req && done ##1 !mem.req)
		else $error("test wrote back");
	a_rmw_same_place: assert property (state_reg == st_read && mem_ack && wr_back |=>
		mem.req && mem.we && mem.addr == $past(mem.addr) && mem.wdata == $past(res))
		else $error("write back to other address");
	a_product_split: assert property (take && !bad && instr.op == product_op |=>
		{idx, acc} == {8'h00, $past(acc)} * {8'h00, $past(idx)} && !flags.c)
		else $error("product placed wrong");

	c_rmw_memory: cover property (state_reg == st_read && mem_ack && wr_back ##1 state_reg == st_write);
	c_branch_taken: cover property (take && instr.iclass == cls_branch && instr.cond);
	c_store_index: cover property (take_mem && instr.op == store_index_op && instr.mode == mode_ix2);
	c_page_one: cover property (take_mem && instr.mode == mode_ix1 && ea_next[8]);

endmodule : cpu_operand_address_generator

`default_nettype wire

// ---- test/mem_partner.sv ----
`timescale 1ns/1ps
`default_nettype none

module mem_partner
	import cpu_oag_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire mem_req_t mem,
	input wire logic [1:0] slow,
	output logic mem_ack,
	output logic [7:0] mem_rdata,
	output logic [15:0] rd_addr,
	output logic [15:0] wr_addr,
	output logic [7:0] wr_data,
	output int wr_cnt
);
	logic [1:0] wait_reg;

	// Every location is readable and writable, so a read-modify-write never meets a write-only cell.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mem_ack <= 1'b0;
			wait_reg <= 2'h0;
			mem_rdata <= 8'h00;
		end else if (mem.req && !mem_ack && wait_reg >= slow) begin
			mem_ack <= 1'b1;
			wait_reg <= 2'h0;
			mem_rdata <= mem.addr[7:0] ^ mem.addr[15:8] ^ 8'h3C;
		end else begin
			mem_ack <= 1'b0;
			wait_reg <= (mem.req && !mem_ack) ? wait_reg + 2'h1 : 2'h0;
			mem_rdata <= ~mem_rdata;
		end
	end

	// Records what each completed access carried.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rd_addr <= 16'h0000;
			wr_addr <= 16'h0000;
			wr_data <= 8'h00;
			wr_cnt <= 0;
		end else if (mem_ack && mem.we) begin
			wr_addr <= mem.addr;
			wr_data <= mem.wdata;
			wr_cnt <= wr_cnt + 1;
		end else if (mem_ack) begin
			rd_addr <= mem.addr;
		end
	end
endmodule : mem_partner

`default_nettype wire

// ---- test/cpu_operand_address_generator_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module cpu_operand_address_generator_bench;
	import cpu_oag_pkg::*;
	logic mclk;
	logic rst_b;
	instr_t instr;
	logic instr_valid;
	logic instr_ready;
	logic mem_ack;
	logic [7:0] mem_rdata;
	mem_req_t mem;
	logic done;
	logic illegal;
	logic [15:0] pc_out;
	logic [7:0] acc;
	logic [7:0] idx;
	flags_t flags;
	logic [1:0] slow;
	logic [15:0] rd_addr;
	logic [15:0] wr_addr;
	logic [7:0] wr_data;
	int wr_cnt;
	int err_count;
	int comparisons;
	int n0;
	logic [7:0] v;
	logic [7:0] b1;
	logic [7:0] b2;
	logic [7:0] keep;
	logic [15:0] pc;
	logic [2:0] bs;
	logic cd;
	op_t o;
	amode_t md;
	logic [7:0] e;
	logic [7:0] xe;
	logic [7:0] rb;
	logic ce;
	logic [8:0] r;

	cpu_operand_address_generator dut_u (.mclk(mclk), .rst_b(rst_b), .instr(instr),
		.instr_valid(instr_valid), .instr_ready(instr_ready), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .mem(mem), .done(done), .illegal(illegal), .pc_out(pc_out),
		.acc(acc), .idx(idx), .flags(flags));

	mem_partner part_u (.mclk(mclk), .rst_b(rst_b), .mem(mem), .slow(slow), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .rd_addr(rd_addr), .wr_addr(wr_addr), .wr_data(wr_data),
		.wr_cnt(wr_cnt));

	function automatic logic [7:0] mv(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3C;
	endfunction : mv

	// Expected carry and result of one operation; a is the register operand of two-operand ops, m the other one or the single altered operand.
	function automatic logic [8:0] ref_op(input op_t op, input logic [7:0] a,
		input logic [7:0] m, input logic ci);
		logic [8:0] w;
		w = {ci, m};
		case (op)
			add_op: w = {1'b0, a} + {1'b0, m};
			add_carry_op: w = {1'b0, a} + {1'b0, m} + {8'h00, ci};
			subtract_op, compare_acc_op, compare_index_op: w = {1'b0, a} - {1'b0, m};
			subtract_borrow_op: w = {1'b0, a} - {1'b0, m} - {8'h00, ci};
			and_acc_op, bit_test_op: w = {ci, a & m};
			xor_acc_op: w = {ci, a ^ m};
			or_acc_op: w = {ci, a | m};
			shift_left_arith_op, shift_left_logic_op: w = {m, 1'b0};
			shift_right_arith_op: w = {m[0], m[7], m[7:1]};
			shift_right_logic_op: w = {m[0], 1'b0, m[7:1]};
			rotate_left_carry_op: w = {m, ci};
			rotate_right_carry_op: w = {m[0], ci, m[7:1]};
			zero_fill_op: w = 9'h000;
			bitwise_invert_op: w = {1'b1, ~m};
			arithmetic_invert_op: w = {m != 8'h00, 8'h00 - m};
			plus_one_op: w = {ci, m + 8'h01};
			minus_one_op: w = {ci, m - 8'h01};
			default: w = {ci, m};
		endcase
		return w;
	endfunction : ref_op

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic exec(input iclass_t c, input amode_t m, input op_t o, input logic [7:0] a,
		input logic [7:0] b, input logic [15:0] p, input logic k, input logic ill);
		int n;
		@(posedge mclk);
		#1;
		check(16'(instr_ready), 16'h0001);
		bs = 3'($urandom);
		instr = '{iclass: c, mode: m, op: o, bit_sel: bs, byte1: a, byte2: b, pc: p, cond: k};
		instr_valid = 1'b1;
		slow = 2'($urandom);
		@(posedge mclk);
		#1;
		instr_valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 100) begin
			@(posedge mclk);
			#1;
			n++;
		end
		check(16'(n < 100), 16'h0001);
		check(16'(illegal), 16'(ill));
	endtask : exec

	task automatic summarize();
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial begin
		#200000;
		err_count++;
		summarize();
	end

	initial begin
		rst_b = 1'b0;
		instr = '0;
		instr_valid = 1'b0;
		slow = 2'h0;
		err_count = 0;
		comparisons = 0;
		n0 = $urandom(32'hB29A);
		repeat (16) @(posedge mclk);
		#1;
		rst_b = 1'b1;
		for (int i = 0; i < 12; i++) begin
			v = (i == 0) ? 8'hFF : 8'($urandom);
			b1 = (i == 0) ? 8'hFF : 8'($urandom);
			b2 = (i == 0) ? 8'hFF : 8'($urandom);
			pc = (i == 0) ? 16'hFFFF : 16'($urandom);
			cd = (i == 0) ? 1'b1 : 1'($urandom);
			exec(cls_reg_mem, mode_dir, load_acc_op, b1, b2, pc, 1'b0, 1'b0);
			check(rd_addr, {8'h00, b1});
			check(16'(acc), 16'(mv({8'h00, b1})));
			exec(cls_reg_mem, mode_ext, load_index_op, b1, b2, pc, 1'b0, 1'b0);
			check(rd_addr, {b1, b2});
			check(16'(idx), 16'(mv({b1, b2})));
			exec(cls_reg_mem, mode_dir, load_index_op, v ^ 8'h3C, b2, pc, 1'b0, 1'b0);
			exec(cls_reg_mem, mode_ix, load_acc_op, b1, b2, pc, 1'b0, 1'b0);
			check(rd_addr, {8'h00, v});
			exec(cls_reg_mem, mode_ix1, load_acc_op, b1, b2, pc, 1'b0, 1'b0);
			check(rd_addr, {8'h00, v} + {8'h00, b1});
			exec(cls_reg_mem, mode_ix2, load_acc_op, b1, b2, pc, 1'b0, 1'b0);
			check(rd_addr, {b1, b2} + {8'h00, v});
			exec(cls_reg_mem, mode_dir, load_acc_op, v ^ 8'h3C, b2, pc, 1'b0, 1'b0);
			exec(cls_reg_mem, mode_ext, store_acc_op, b1, b2, pc, 1'b0, 1'b0);
			check(wr_addr, {b1, b2});
			check(16'(wr_data), 16'(v));
			exec(cls_rmw, mode_ext, plus_one_op, b1, b2, pc, 1'b0, 1'b0);
			check(wr_addr, rd_addr);
			check(16'(wr_data), 16'(8'(mv({b1, b2}) + 8'h01)));
			exec(cls_rmw, mode_dir, shift_right_logic_op, b1, b2, pc, 1'b0, 1'b0);
			check(16'(wr_data), 16'(mv({8'h00, b1}) >> 1));
			n0 = wr_cnt;
			exec(cls_rmw, mode_dir, test_flags_only_op, b1, b2, pc, 1'b0, 1'b0);
			check(16'(wr_cnt), 16'(n0));
			exec(cls_rmw, mode_ext, bit_raise_op, b1, b2, pc, 1'b0, 1'b1);
			check(16'(wr_cnt), 16'(n0));
			exec(cls_rmw, mode_dir, bit_raise_op, b1, b2, pc, 1'b0, 1'b0);
			check(16'(wr_data), 16'(mv({8'h00, b1}) | (8'h01 << bs)));
			exec(cls_rmw, mode_dir, bit_reset_op, b1, b2, pc, 1'b0, 1'b0);
			check(16'(wr_data), 16'(mv({8'h00, b1}) & ~(8'h01 << bs)));
			$display("memory scenario %0d done", i);
			exec(cls_branch, mode_rel, branch_op, b1, b2, pc, cd, 1'b0);
			check(pc_out, cd ? pc + {{8{b1[7]}}, b1} : pc);
			keep = acc;
			exec(cls_reg_mem, mode_rel, load_acc_op, b1, b2, ~pc, 1'b1, 1'b1);
			check(16'(acc), 16'(keep));
			check(pc_out, cd ? pc + {{8{b1[7]}}, b1} : pc);
			// Every arithmetic, logic and register-form operation except product, test, the stores and bit set/clear, chained on tracked values.
			e = v;
			xe = v;
			ce = 1'b0;
			for (int k = 0; k < 28; k++) begin
				o = op_t'(k);
				if (o inside {product_op, store_acc_op, store_index_op, bit_reset_op,
					bit_raise_op}) begin
					continue;
				end
				rb = 8'($urandom);
				if (k < 15) begin
					exec(cls_reg_mem, mode_dir, o, rb, b2, pc, 1'b0, 1'b0);
					r = ref_op(o, (o == compare_index_op) ? xe : e, mv({8'h00, rb}), ce);
					if (o inside {add_op, add_carry_op, and_acc_op, xor_acc_op, or_acc_op,
						load_acc_op, subtract_op, subtract_borrow_op}) begin
						e = r[7:0];
					end else if (o == load_index_op) begin
						xe = r[7:0];
					end
				end else begin
					md = (k % 2 == 1) ? mode_inh_x : mode_inh_a;
					exec(cls_rmw, md, o, rb, b2, pc, 1'b0, 1'b0);
					r = ref_op(o, 8'h00, (md == mode_inh_x) ? xe : e, ce);
					if (md == mode_inh_x) begin
						xe = r[7:0];
					end else begin
						e = r[7:0];
					end
				end
				ce = r[8];
				check(16'(acc), 16'(e));
				check(16'(idx), 16'(xe));
				check(16'({flags.n, flags.z, flags.c}), 16'({r[7], r[7:0] == 8'h00, r[8]}));
			end
			exec(cls_reg_mem, mode_ix2, store_index_op, b1, b2, pc, 1'b0, 1'b0);
			check(wr_addr, {b1, b2} + {8'h00, xe});
			check(16'(wr_data), 16'(xe));
			$display("register operation scenario %0d done", i);
			exec(cls_reg_mem, mode_dir, load_index_op, b2 ^ 8'h3C, b2, pc, 1'b0, 1'b0);
			exec(cls_reg_mem, mode_inh_a, product_op, b1, b2, pc, 1'b0, 1'b0);
			check({idx, acc}, {8'h00, e} * {8'h00, b2});
			$display("branch and product scenario %0d done", i);
		end
		summarize();
	end
endmodule : cpu_operand_address_generator_bench

`default_nettype wire
